/* File: core/slc_pkg.sv */
package slc_pkg;

  // ************************************************************
  // register indices on the serial register port
  // ************************************************************
  localparam logic [7:0] SLC_ADDR_HS_MODES   = 8'h00;
  localparam logic [7:0] SLC_ADDR_AUX_MODES  = 8'h01;
  localparam logic [7:0] SLC_ADDR_RX_SET     = 8'h02;
  localparam logic [7:0] SLC_ADDR_TERM_PULSE1 = 8'h03;
  localparam logic [7:0] SLC_ADDR_TERM_PULSE2 = 8'h04;
  localparam logic [7:0] SLC_ADDR_EQ1        = 8'h05;
  localparam logic [7:0] SLC_ADDR_EQ2        = 8'h06;
  localparam logic [7:0] SLC_ADDR_TX_SET     = 8'h07;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SLC_MODE_EN_BIT    = 6;
  localparam int SLC_MODE_SM_LSB    = 4;
  localparam int SLC_MODE_CH_LSB    = 0;
  localparam int SLC_RX_TERM_BIT    = 0;
  localparam int SLC_OUTPUT_PREEMPH_LEVEL_LSB      = 2;
  localparam int SLC_TX_TERM_BIT    = 1;
  localparam int SLC_TX_CUR_BIT     = 0;
  localparam logic [1:0] SLC_SM_QUAD    = 2'h0;
  localparam logic [1:0] SLC_SM_ILLEGAL = 2'h3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] SLC_RST_HS_MODES  = 8'h00;
  localparam logic [7:0] SLC_RST_AUX_MODES = 8'h40;
  localparam logic [7:0] SLC_RST_RX_SET    = 8'h01;
  localparam logic [7:0] SLC_RST_PULSE     = 8'h00;
  localparam logic [7:0] SLC_RST_EQ        = 8'h00;
  localparam logic [7:0] SLC_RST_TX_SET    = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SLC_CLK_KHZ       = 25000;
  localparam int SLC_TERM_PULSE_MS = 100;
  localparam int SLC_TERM_PULSE_CYC = SLC_CLK_KHZ * SLC_TERM_PULSE_MS;
  localparam int SLC_CHANNELS      = 16;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic       switch_enable;
    logic [1:0] source_sel;
    logic       eq_level;
    logic [1:0] preemph_field;
    logic       output_term;
    logic       output_current;
  } slc_strap_t;

  typedef struct packed {
    logic        hs_enable;
    logic [1:0]  hs_mode;
    logic [3:0]  hs_source;
    logic        aux_enable;
    logic [1:0]  aux_mode;
    logic [3:0]  aux_source;
    logic [15:0] input_eq_level;
    logic [1:0]  output_preemph_level;
    logic        output_term_enable;
    logic        output_current_sel;
  } slc_cfg_t;

endpackage

/* File: core/slc_pulse_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module slc_pulse_timer
  import slc_pkg::*;
#(
  parameter int LEN_CYC = SLC_TERM_PULSE_CYC,
  parameter int CNT_W   = 22
)
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // control
  input  wire logic trig_i,
  output logic      active_o
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             active_reg;
  logic             active_next;

  // ************************************************************
  // disconnect window counter, restarted by every trigger
  // ************************************************************
  always_comb
  begin
    cnt_next    = cnt_reg;
    active_next = active_reg;
    if (trig_i)
    begin
      cnt_next    = CNT_W'(LEN_CYC - 1);
      active_next = 1'b1;
    end
    else if (active_reg)
    begin
      if (cnt_reg == '0)
      begin
        active_next = 1'b0;
      end
      else
      begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cnt_reg    <= '0;
      active_reg <= 1'b0;
    end
    else
    begin
      cnt_reg    <= cnt_next;
      active_reg <= active_next;
    end
  end

  assign active_o = active_reg;

endmodule

`default_nettype wire

/* File: core/slc_config_regs.sv */
// How it works
// - termination select 0 disconnects inputs; 1 connects, subject to pulsing.
// - channel with pulse bit 1 loses termination 100 ms per high speed source switch.
// - pulse vector bits 0-3 B0-B3, 4-7 A0-A3, 8-11 C3-C0, 12-15 D3-D0.
// - equalization bit 0 gives 6 dB, 1 gives 12 dB for its channel.
// - equalization vector uses the same channel order as the pulse vector.
// - two-bit pre-emphasis field sets 0, 2, 4 or 6 dB on all outputs.
// - output termination bit: 0 removes, 1 connects, for all outputs.
// - output current bit: 0 gives 10 mA, 1 gives 20 mA, all outputs.
// - registers load from strap pin levels through a two-flop synchroniser.
// - straps apply only after reset until the first serial register access.
// - strap mode: enable bit 6 from strap, bits 5-2 zero, 1-0 source straps.
// - strap mode: auxiliary enable 1, mode zero, source from source straps.
// - first pulse register holds A and B bits; straps keep termination on.
// - one equalization strap drives every input channel.
// - straps disable pulse-on-switch on all channels.
// - strap source 00 A, 01 B, 10 C, 11 D to outputs.
`timescale 1ns/1ps
`default_nettype none

module slc_config_regs
  import slc_pkg::*;
#(
  parameter int TERM_PULSE_CYC = SLC_TERM_PULSE_CYC,
  parameter int TIMER_W        = 22
)
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // register port from the serial control engine
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // strap pins
  input  wire logic        strap_switch_enable_i,
  input  wire logic [1:0]  strap_source_sel_i,
  input  wire logic        strap_eq_level_i,
  input  wire logic [1:0]  strap_preemph_field_i,
  input  wire logic        strap_output_term_i,
  input  wire logic        strap_output_current_i,
  // configuration to the switch and front ends
  output slc_cfg_t         cfg_o,
  output logic [15:0]      input_term_on_o,
  output logic             strap_phase_o
);

  // ************************************************************
  // strap synchroniser
  // ************************************************************
  slc_strap_t strap_meta_reg;
  slc_strap_t strap_sync_reg;
  slc_strap_t strap_pins;

  // pin group packed for the two-stage synchroniser
  assign strap_pins = '{switch_enable:  strap_switch_enable_i,
                        source_sel:     strap_source_sel_i,
                        eq_level:       strap_eq_level_i,
                        preemph_field:  strap_preemph_field_i,
                        output_term:    strap_output_term_i,
                        output_current: strap_output_current_i};

  // two flops before any use
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end
    else
    begin
      strap_meta_reg <= strap_pins;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] hs_modes_reg;
  logic [7:0] hs_modes_next;
  logic [7:0] aux_modes_reg;
  logic [7:0] aux_modes_next;
  logic [7:0] rx_set_reg;
  logic [7:0] rx_set_next;
  logic [7:0] pulse1_reg;
  logic [7:0] pulse1_next;
  logic [7:0] pulse2_reg;
  logic [7:0] pulse2_next;
  logic [7:0] eq1_reg;
  logic [7:0] eq1_next;
  logic [7:0] eq2_reg;
  logic [7:0] eq2_next;
  logic [7:0] tx_set_reg;
  logic [7:0] tx_set_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       strap_phase_reg;
  logic       strap_phase_next;
  logic       any_access;

  assign any_access = reg_wr_i | reg_rd_i;

  // next register values: strap load, then serial writes
  always_comb
  begin
    hs_modes_next    = hs_modes_reg;
    aux_modes_next   = aux_modes_reg;
    rx_set_next      = rx_set_reg;
    pulse1_next      = pulse1_reg;
    pulse2_next      = pulse2_reg;
    eq1_next         = eq1_reg;
    eq2_next         = eq2_reg;
    tx_set_next      = tx_set_reg;
    strap_phase_next = strap_phase_reg;
    if (any_access)
    begin
      strap_phase_next = 1'b0;
    end
    if (strap_phase_reg && !any_access)
    begin
      hs_modes_next  = {1'b0, strap_sync_reg.switch_enable, 4'h0,
                        strap_sync_reg.source_sel};
      aux_modes_next = {1'b0, 1'b1, 4'h0, strap_sync_reg.source_sel};
      rx_set_next    = SLC_RST_RX_SET;
      pulse1_next    = 8'h00;
      pulse2_next    = 8'h00;
      eq1_next       = {8{strap_sync_reg.eq_level}};
      eq2_next       = {8{strap_sync_reg.eq_level}};
      tx_set_next    = {4'h0, strap_sync_reg.preemph_field,
                        strap_sync_reg.output_term, strap_sync_reg.output_current};
    end
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        SLC_ADDR_HS_MODES:    hs_modes_next = {1'b0, reg_wdata_i[6:0]};
        SLC_ADDR_AUX_MODES:
        begin
          aux_modes_next = {1'b0, reg_wdata_i[6:0]};
          // illegal mode code keeps the old mode
          if (reg_wdata_i[SLC_MODE_SM_LSB +: 2] == SLC_SM_ILLEGAL)
          begin
            aux_modes_next[SLC_MODE_SM_LSB +: 2] = aux_modes_reg[SLC_MODE_SM_LSB +: 2];
          end
        end
        SLC_ADDR_RX_SET:      rx_set_next = {7'h00, reg_wdata_i[SLC_RX_TERM_BIT]};
        SLC_ADDR_TERM_PULSE1: pulse1_next = reg_wdata_i;
        SLC_ADDR_TERM_PULSE2: pulse2_next = reg_wdata_i;
        SLC_ADDR_EQ1:         eq1_next = reg_wdata_i;
        SLC_ADDR_EQ2:         eq2_next = reg_wdata_i;
        SLC_ADDR_TX_SET:      tx_set_next = {4'h0, reg_wdata_i[3:0]};
        default:              hs_modes_next = hs_modes_reg;
      endcase
    end
  end

  // read data, unmapped indices read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        SLC_ADDR_HS_MODES:    rdata_next = hs_modes_reg;
        SLC_ADDR_AUX_MODES:   rdata_next = aux_modes_reg;
        SLC_ADDR_RX_SET:      rdata_next = rx_set_reg;
        SLC_ADDR_TERM_PULSE1: rdata_next = pulse1_reg;
        SLC_ADDR_TERM_PULSE2: rdata_next = pulse2_reg;
        SLC_ADDR_EQ1:         rdata_next = eq1_reg;
        SLC_ADDR_EQ2:         rdata_next = eq2_reg;
        SLC_ADDR_TX_SET:      rdata_next = tx_set_reg;
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      hs_modes_reg    <= SLC_RST_HS_MODES;
      aux_modes_reg   <= SLC_RST_AUX_MODES;
      rx_set_reg      <= SLC_RST_RX_SET;
      pulse1_reg      <= SLC_RST_PULSE;
      pulse2_reg      <= SLC_RST_PULSE;
      eq1_reg         <= SLC_RST_EQ;
      eq2_reg         <= SLC_RST_EQ;
      tx_set_reg      <= SLC_RST_TX_SET;
      rdata_reg       <= 8'h00;
      strap_phase_reg <= 1'b1;
    end
    else
    begin
      hs_modes_reg    <= hs_modes_next;
      aux_modes_reg   <= aux_modes_next;
      rx_set_reg      <= rx_set_next;
      pulse1_reg      <= pulse1_next;
      pulse2_reg      <= pulse2_next;
      eq1_reg         <= eq1_next;
      eq2_reg         <= eq2_next;
      tx_set_reg      <= tx_set_next;
      rdata_reg       <= rdata_next;
      strap_phase_reg <= strap_phase_next;
    end
  end

  // ************************************************************
  // source switch detection and disconnect timer
  // ************************************************************
  logic [3:0] src_prev_reg;
  logic [3:0] src_prev_next;
  logic       src_switch;
  logic       disc_active;

  // a change of the high speed source field is a switch
  always_comb
  begin
    src_prev_next = hs_modes_reg[SLC_MODE_CH_LSB +: 4];
    src_switch    = (src_prev_reg != hs_modes_reg[SLC_MODE_CH_LSB +: 4]);
  end

  // previous source
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      src_prev_reg <= 4'h0;
    end
    else
    begin
      src_prev_reg <= src_prev_next;
    end
  end

  slc_pulse_timer #(
    .LEN_CYC (TERM_PULSE_CYC),
    .CNT_W   (TIMER_W)
  ) u_pulse_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .trig_i    (src_switch),
    .active_o  (disc_active)
  );

  // ************************************************************
  // per-channel input termination
  // ************************************************************
  logic [15:0] pulse_vec;
  logic [15:0] term_on_reg;
  logic [15:0] term_on_next;

  assign pulse_vec = {pulse2_reg, pulse1_reg};

  genvar ch;
  generate
    for (ch = 0; ch < SLC_CHANNELS; ch++)
    begin : g_term
      // pulse bit 1 opens the channel during the window
      always_comb
      begin
        term_on_next[ch] = rx_set_reg[SLC_RX_TERM_BIT] &
                           ~(pulse_vec[ch] & disc_active);
      end
    end
  endgenerate

  // registered termination drive
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      term_on_reg <= 16'h0000;
    end
    else
    begin
      term_on_reg <= term_on_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign input_term_on_o = term_on_reg;
  assign reg_rdata_o     = rdata_reg;
  assign strap_phase_o   = strap_phase_reg;

  // configuration fields straight from registers
  always_comb
  begin
    cfg_o.hs_enable            = hs_modes_reg[SLC_MODE_EN_BIT];
    cfg_o.hs_mode              = hs_modes_reg[SLC_MODE_SM_LSB +: 2];
    cfg_o.hs_source            = hs_modes_reg[SLC_MODE_CH_LSB +: 4];
    cfg_o.aux_enable           = aux_modes_reg[SLC_MODE_EN_BIT];
    cfg_o.aux_mode             = aux_modes_reg[SLC_MODE_SM_LSB +: 2];
    cfg_o.aux_source           = aux_modes_reg[SLC_MODE_CH_LSB +: 4];
    cfg_o.input_eq_level       = {eq2_reg, eq1_reg};
    cfg_o.output_preemph_level = tx_set_reg[SLC_OUTPUT_PREEMPH_LEVEL_LSB +: 2];
    cfg_o.output_term_enable   = tx_set_reg[SLC_TX_TERM_BIT];
    cfg_o.output_current_sel   = tx_set_reg[SLC_TX_CUR_BIT];
  end

endmodule

`default_nettype wire

/* File: bench/slc_config_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none

module slc_config_regs_props
  import slc_pkg::*;
#(
  parameter int TERM_PULSE_CYC = SLC_TERM_PULSE_CYC
)
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [7:0]  reg_rdata_o,
  // strap pins
  input  wire logic        strap_switch_enable_i,
  input  wire logic [1:0]  strap_source_sel_i,
  input  wire logic        strap_eq_level_i,
  input  wire logic [1:0]  strap_preemph_field_i,
  input  wire logic        strap_output_term_i,
  input  wire logic        strap_output_current_i,
  // configuration outputs
  input  wire slc_cfg_t    cfg_o,
  input  wire logic [15:0] input_term_on_o,
  input  wire logic        strap_phase_o
);
  localparam int AGE_DONE = TERM_PULSE_CYC + 1;

  // ************************************************************
  // shadow of the termination settings
  // ************************************************************
  logic [15:0] pulse_reg;
  logic [15:0] pulse_next;
  logic        rx_reg;
  logic        rx_next;
  logic [3:0]  src_reg;
  int          age_reg;

  // next shadow values from register writes
  always_comb
  begin
    pulse_next = pulse_reg;
    rx_next    = rx_reg;
    if (reg_wr_i && reg_addr_i == SLC_ADDR_TERM_PULSE1)
      pulse_next[7:0] = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == SLC_ADDR_TERM_PULSE2)
      pulse_next[15:8] = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == SLC_ADDR_RX_SET)
      rx_next = reg_wdata_i[SLC_RX_TERM_BIT];
  end

  // shadow registers
  always_ff @(posedge clk_sys_i)
  begin
    pulse_reg <= rst_i ? 16'h0000 : pulse_next;
    rx_reg    <= rst_i ? 1'b1 : rx_next;
  end

  // cycles since the last source switch, saturating once the window is over
  always_ff @(posedge clk_sys_i)
  begin
    src_reg <= cfg_o.hs_source;
    if (rst_i || cfg_o.hs_source != src_reg)
      age_reg <= 0;
    else if (age_reg < AGE_DONE)
      age_reg <= age_reg + 1;
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // source switch seen with termination enabled
  sequence s_switch;
    $changed(cfg_o.hs_source) && rx_reg;
  endsequence
  // any register access
  sequence s_access;
    reg_wr_i || reg_rd_i;
  endsequence

  a_term_off: assert property (!$past(rst_i) && !$past(rx_reg) |->
    input_term_on_o == 16'h0000) else $error("termination not off");
  a_keep_term: assert property (!$past(rst_i) && $past(rx_reg) |->
    (input_term_on_o | $past(pulse_reg)) == 16'hFFFF) else $error("unpulsed channel dropped");
  a_pulse_drop: assert property (s_switch |-> ##2
    (input_term_on_o & pulse_reg) == 16'h0000) else $error("pulsed channel kept on");
  a_pulse_end: assert property (age_reg == AGE_DONE && $past(rx_reg) |->
    input_term_on_o == 16'hFFFF) else $error("termination not restored");
  a_tx_write: assert property (reg_wr_i && reg_addr_i == SLC_ADDR_TX_SET |=>
    {cfg_o.output_preemph_level, cfg_o.output_term_enable, cfg_o.output_current_sel}
    == $past(reg_wdata_i[3:0])) else $error("transmit settings wrong");
  a_eq_write: assert property (reg_wr_i && reg_addr_i == SLC_ADDR_EQ2 |=>
    cfg_o.input_eq_level[15:8] == $past(reg_wdata_i)) else $error("eq high byte wrong");
  a_rd_eq: assert property (reg_rd_i && reg_addr_i == SLC_ADDR_EQ1 |=>
    reg_rdata_o == $past(cfg_o.input_eq_level[7:0])) else $error("eq read wrong");
  a_phase_end: assert property (s_access |=> !strap_phase_o)
    else $error("strap phase kept");
  a_phase_stays: assert property (!strap_phase_o |=> !strap_phase_o)
    else $error("strap phase returned");
  a_strap_modes: assert property (strap_phase_o |-> cfg_o.hs_mode == SLC_SM_QUAD &&
    cfg_o.aux_enable && cfg_o.aux_mode == SLC_SM_QUAD && cfg_o.hs_source[3:2] == 2'h0
    && cfg_o.aux_source == cfg_o.hs_source) else $error("strap modes wrong");
  a_strap_term: assert property (strap_phase_o && $past(strap_phase_o) && !$past(rst_i) |->
    input_term_on_o == 16'hFFFF) else $error("strap termination off");
  a_strap_eq: assert property (strap_phase_o |->
    cfg_o.input_eq_level == {16{cfg_o.input_eq_level[0]}}) else $error("strap eq split");
endmodule

bind slc_config_regs slc_config_regs_props #(.TERM_PULSE_CYC(TERM_PULSE_CYC))
  slc_config_regs_props_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .strap_switch_enable_i(strap_switch_enable_i),
  .strap_source_sel_i(strap_source_sel_i), .strap_eq_level_i(strap_eq_level_i),
  .strap_preemph_field_i(strap_preemph_field_i), .strap_output_term_i(strap_output_term_i),
  .strap_output_current_i(strap_output_current_i), .cfg_o(cfg_o),
  .input_term_on_o(input_term_on_o), .strap_phase_o(strap_phase_o));

`default_nettype wire

/* File: bench/slc_strap_model.sv */
`timescale 1ns/1ps
`default_nettype none

module slc_strap_model
  import slc_pkg::*;
(
  // board strap setting
  input  wire slc_strap_t  strap_i,
  // strap pins
  output logic             switch_enable_o,
  output logic [1:0]       source_sel_o,
  output logic             eq_level_o,
  output logic [1:0]       preemph_field_o,
  output logic             output_term_o,
  output logic             output_current_o
);
  // pins tied to supply for 1 and ground for 0
  assign {switch_enable_o, source_sel_o, eq_level_o, preemph_field_o, output_term_o,
          output_current_o} = strap_i;
endmodule

`default_nettype wire

/* File: bench/slc_config_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module slc_config_regs_tb_top
  import slc_pkg::*;
;
  localparam int PULSE = 20;
  localparam logic [15:0] TBL [9] = '{16'hFF7F, 16'h6F7F, 16'hFF01, 16'hFFFF, 16'hFFFF,
                                      16'hFFFF, 16'hFFFF, 16'hFF0F, 16'hFF00};
  logic        clk_sys_i;
  logic        rst_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  slc_strap_t  strap;
  logic        sw_en;
  logic [1:0]  src;
  logic        eq;
  logic [1:0]  pe;
  logic        oterm;
  logic        ocur;
  slc_cfg_t    cfg_o;
  logic [15:0] input_term_on_o;
  logic        strap_phase_o;
  int          miscompares;
  int          checked;
  logic [7:0]  lfsr_reg;
  logic [7:0]  q[$];

  // ************************************************************
  // design, strap pins and clock
  // ************************************************************
  slc_config_regs #(.TERM_PULSE_CYC(PULSE)) slc_config_regs_i (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .strap_switch_enable_i(sw_en),
    .strap_source_sel_i(src), .strap_eq_level_i(eq), .strap_preemph_field_i(pe),
    .strap_output_term_i(oterm), .strap_output_current_i(ocur), .cfg_o(cfg_o),
    .input_term_on_o(input_term_on_o), .strap_phase_o(strap_phase_o));
  slc_strap_model slc_strap_model_i (.strap_i(strap), .switch_enable_o(sw_en),
    .source_sel_o(src), .eq_level_o(eq), .preemph_field_o(pe), .output_term_o(oterm),
    .output_current_o(ocur));

  // free running clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [39:0] e, input logic [39:0] a);
    checked++;
    if (a !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // read request; the expected data goes to the queue
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    q.push_back(e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask

  // counts edges until the termination vector is full or not
  task automatic count_term(input logic want_full, output int n);
    n = 0;
    while (((input_term_on_o === 16'hFFFF) != want_full) && n < 200)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n == 200)
    begin
      miscompares++;
      stop_test();
    end
  endtask

  // read data monitor, one cycle after the strobe
  always @(posedge clk_sys_i)
    if (reg_rd_i === 1'b1)
    begin
      #1;
      chk(40'(q.pop_front()), 40'(reg_rdata_o));
    end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    int n;
    logic [7:0] d;
    rst_i       = 1'b1;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    strap       = 8'h00;
    lfsr_reg    = 8'h23;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys_i);
      strap <= {s[0], s[1:0], s[1], s[1:0], s[1], s[0]};
      idle(6);
      chk({6'h0, s[0], 4'h0, s[1:0], 5'h10, s[1:0], {16{s[1]}}, s[1:0], s[1], s[0]},
          {6'h0, cfg_o});
      chk(40'(16'hFFFF), 40'(input_term_on_o));
    end
    $display("test strap load done");
    rd(SLC_ADDR_RX_SET, 8'h01);
    strap <= 8'h00;
    idle(6);
    chk(40'(16'hFFFF), 40'(cfg_o.input_eq_level));
    chk(40'(1'b0), 40'(strap_phase_o));
    $display("test strap freeze done");
    repeat (3)
      for (int i = 0; i < 9; i++)
      begin
        lfsr_reg = lfsr_next(lfsr_reg);
        d = (lfsr_reg & TBL[i][15:8]) | {7'h0, i == 2};
        wr(i[7:0], d);
        rd(i[7:0], d & TBL[i][7:0]);
      end
    rd(8'hFF, 8'h00);
    $display("test register table done");
    for (int p = 0; p < 4; p++)
    begin
      wr(SLC_ADDR_TX_SET, {4'h0, p[1:0], p[0], p[1]});
      idle(1);
      chk({36'h0, p[1:0], p[0], p[1]}, {36'h0, cfg_o.output_preemph_level,
          cfg_o.output_term_enable, cfg_o.output_current_sel});
    end
    wr(SLC_ADDR_EQ1, 8'hA5);
    wr(SLC_ADDR_EQ2, 8'h3C);
    idle(1);
    chk(40'(16'h3CA5), 40'(cfg_o.input_eq_level));
    $display("test output settings done");
    wr(SLC_ADDR_RX_SET, 8'h01);
    wr(SLC_ADDR_TERM_PULSE1, 8'h0F);
    wr(SLC_ADDR_TERM_PULSE2, 8'h80);
    wr(SLC_ADDR_HS_MODES, 8'h40);
    idle(PULSE + 10);
    chk(40'(16'hFFFF), 40'(input_term_on_o));
    wr(SLC_ADDR_HS_MODES, 8'h41);
    count_term(1'b0, n);
    chk(40'(2), 40'(n));
    chk(40'(16'h7FF0), 40'(input_term_on_o));
    idle(8);
    wr(SLC_ADDR_HS_MODES, 8'h42);
    count_term(1'b1, n);
    chk(40'(PULSE + 2), 40'(n));
    wr(SLC_ADDR_RX_SET, 8'h00);
    idle(3);
    chk(40'(16'h0000), 40'(input_term_on_o));
    $display("test termination done");
    idle(2);
    stop_test();
  end
endmodule

`default_nettype wire
